/* rtl/fifo_host_pkg.sv */
// Package with timing constants, modes and pin groups for the FIFO host controller.
package fifo_host_pkg;

   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned DEPTH = 512;
   localparam int unsigned WIDTH = 9;
   localparam int unsigned ADDR_W = 9;

   // Pulse and interval figures in ns.
   localparam int unsigned T_PULSE_NS = 65;
   localparam int unsigned T_RECOVER_NS = 15;
   localparam int unsigned T_REWIND_SETUP_NS = 45;
   localparam int unsigned T_CLEAR_SETUP_NS = 45;
   localparam int unsigned T_ACCESS_NS = 65;
   localparam int unsigned T_FLAG_NS = 60;

   // Least times round up.
   localparam int unsigned PULSE_CYC = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RECOVER_CYC = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned REWIND_SETUP_CYC =
      (T_REWIND_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CLEAR_SETUP_CYC =
      (T_CLEAR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned FLAG_CYC = (T_FLAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam logic [7:0] CNT_ZERO = 8'h00;

   // Device mode chosen at clear time.
   typedef enum logic [1:0]
   {
      MODE_SINGLE = 2'b00,
      MODE_WIDTH = 2'b01,
      MODE_DEPTH = 2'b10
   } mode_t;

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_CLEAR = 3'b001,
      ST_WRITE = 3'b010,
      ST_READ = 3'b011,
      ST_REWIND = 3'b100,
      ST_RECOVER = 3'b101,
      ST_SETUP = 3'b110
   } state_t;

   // Pins driven toward the FIFO devices.
   typedef struct packed
   {
      logic pointer_clear_n;
      logic write_n;
      logic read_n;
      logic head_select_or_rewind_n;
      logic chain_in_n;
      logic [WIDTH-1:0] wdata;
   } fifo_ctl_t;

   // Pins sampled from the FIFO devices.
   typedef struct packed
   {
      logic [1:0] full_flag_n;
      logic [1:0] empty_flag_n;
      logic [2*WIDTH-1:0] rdata;
   } fifo_stat_t;

endpackage

/* rtl/host_log_mem.sv */
// Small memory that keeps the host's copy of written words for rewind checking.
`timescale 1ns/1ns
module host_log_mem
(
   // Clock
   input wire logic clk_i,
   // Write port
   input wire logic we_i,
   input wire logic [fifo_host_pkg::ADDR_W-1:0] waddr_i,
   input wire logic [fifo_host_pkg::WIDTH-1:0] wdata_i,
   // Read port
   input wire logic [fifo_host_pkg::ADDR_W-1:0] raddr_i,
   output logic [fifo_host_pkg::WIDTH-1:0] rdata_o
);

   logic [fifo_host_pkg::WIDTH-1:0] mem [fifo_host_pkg::DEPTH];

   always_ff @(posedge clk_i)
   begin
      if (we_i)
      begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
   end

endmodule

/* rtl/fifo_host_ctrl.sv */
// Host controller that drives a width-expanded pair of 512 x 9 FIFOs through their pins.
`timescale 1ns/1ns
// Overview of operation
// - Rewind is a low pulse, then high.
// - Read strobe idle around rewind rising edge.
// - Rewind only when under 512 words written.
// - No rewind in depth chain mode.
// - Width pair shares controls; flags from any.
// - Depth chain flags combined by external logic.
// - Head device held low at clear.
// - Other chain devices held high at clear.
// - Chain output feeds next chain input.
// - Chain pulse set-up, width and recovery.
// - No pulse narrower than its minimum.
// - Watch full of written, empty of read.
module fifo_host_ctrl
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // User commands, one-cycle requests
   input wire logic clear_req_i,
   input wire logic write_req_i,
   input wire logic [fifo_host_pkg::WIDTH-1:0] write_data_i,
   input wire logic read_req_i,
   input wire logic rewind_req_i,
   // User answers
   output logic busy_o,
   output logic read_valid_o,
   output logic [2*fifo_host_pkg::WIDTH-1:0] read_data_o,
   output logic rewind_refused_o,
   output logic mismatch_o,
   // FIFO pins
   output fifo_host_pkg::fifo_ctl_t fifo_ctl_o,
   input wire fifo_host_pkg::fifo_stat_t fifo_stat_i
);

   typedef struct packed
   {
      fifo_host_pkg::state_t st;
      fifo_host_pkg::state_t after;
      logic [7:0] cnt;
      logic [fifo_host_pkg::ADDR_W:0] wr_count;
      logic [fifo_host_pkg::ADDR_W-1:0] rd_idx;
      logic busy;
      logic read_valid;
      logic [2*fifo_host_pkg::WIDTH-1:0] read_data;
      logic rewind_refused;
      logic mismatch;
      logic check_pending;
      fifo_host_pkg::fifo_ctl_t ctl;
   } host_state_t;

   localparam host_state_t RESET_STATE = '{
      st: fifo_host_pkg::ST_IDLE,
      after: fifo_host_pkg::ST_IDLE,
      cnt: fifo_host_pkg::CNT_ZERO,
      wr_count: '0,
      rd_idx: '0,
      busy: 1'b0,
      read_valid: 1'b0,
      read_data: '0,
      rewind_refused: 1'b0,
      mismatch: 1'b0,
      check_pending: 1'b0,
      ctl: '{pointer_clear_n: 1'b1, write_n: 1'b1, read_n: 1'b1,
             head_select_or_rewind_n: 1'b1, chain_in_n: 1'b0, wdata: '0}
   };

   // A cycle count sized for the counter, taken from a package figure.
   function automatic logic [7:0] cyc(input int unsigned n);
      cyc = n[7:0];
   endfunction

   host_state_t s;
   host_state_t next_s;
   logic full_seen;
   logic empty_seen;
   logic [fifo_host_pkg::WIDTH-1:0] log_rdata;
   logic log_we;

   // Both devices share every control, so either flag suffices.
   assign full_seen = ~fifo_stat_i.full_flag_n[0];
   assign empty_seen = ~fifo_stat_i.empty_flag_n[0];
   assign log_we = (s.st == fifo_host_pkg::ST_WRITE) && (s.cnt == fifo_host_pkg::CNT_ZERO);

   host_log_mem u_log
   (
      .clk_i(clk_i),
      .we_i(log_we),
      .waddr_i(s.wr_count[fifo_host_pkg::ADDR_W-1:0]),
      .wdata_i(s.ctl.wdata),
      .raddr_i(s.rd_idx),
      .rdata_o(log_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_s = s;
      next_s.read_valid = 1'b0;
      next_s.rewind_refused = 1'b0;
      // The log word for the last read appears one cycle after the read finished.
      if (s.check_pending)
      begin
         next_s.check_pending = 1'b0;
         if (s.read_data[fifo_host_pkg::WIDTH-1:0] != log_rdata)
         begin
            next_s.mismatch = 1'b1;
         end
         next_s.rd_idx = s.rd_idx + 1'b1;
      end
      case (s.st)
         fifo_host_pkg::ST_IDLE:
         begin
            next_s.busy = 1'b0;
            if (clear_req_i)
            begin
               // Chain input low selects single mode; no chain is formed.
               next_s.ctl.pointer_clear_n = 1'b0;
               next_s.ctl.chain_in_n = 1'b0;
               next_s.ctl.head_select_or_rewind_n = 1'b1;
               next_s.ctl.write_n = 1'b1;
               next_s.ctl.read_n = 1'b1;
               next_s.cnt = cyc(fifo_host_pkg::PULSE_CYC - 1);
               next_s.st = fifo_host_pkg::ST_CLEAR;
               next_s.wr_count = '0;
               next_s.rd_idx = '0;
               next_s.mismatch = 1'b0;
               next_s.busy = 1'b1;
            end
            else if (rewind_req_i)
            begin
               // Single mode only, and only while the written block is intact.
               if (s.wr_count >= (fifo_host_pkg::ADDR_W + 1)'(fifo_host_pkg::DEPTH))
               begin
                  next_s.rewind_refused = 1'b1;
               end
               else
               begin
                  next_s.ctl.head_select_or_rewind_n = 1'b0;
                  next_s.cnt = cyc(fifo_host_pkg::PULSE_CYC - 1);
                  next_s.st = fifo_host_pkg::ST_REWIND;
                  next_s.rd_idx = '0;
                  next_s.busy = 1'b1;
               end
            end
            else if (write_req_i && !full_seen)
            begin
               // Never start a strobe into a full device.
               next_s.ctl.wdata = write_data_i;
               next_s.ctl.write_n = 1'b0;
               next_s.cnt = cyc(fifo_host_pkg::PULSE_CYC - 1);
               next_s.st = fifo_host_pkg::ST_WRITE;
               next_s.busy = 1'b1;
            end
            else if (read_req_i && !empty_seen)
            begin
               // Never start a strobe on an empty device.
               next_s.ctl.read_n = 1'b0;
               next_s.cnt = cyc(fifo_host_pkg::PULSE_CYC - 1);
               next_s.st = fifo_host_pkg::ST_READ;
               next_s.busy = 1'b1;
            end
         end
         fifo_host_pkg::ST_CLEAR:
         begin
            if (s.cnt == fifo_host_pkg::CNT_ZERO)
            begin
               next_s.ctl.pointer_clear_n = 1'b1;
               next_s.cnt = cyc(fifo_host_pkg::RECOVER_CYC);
               next_s.st = fifo_host_pkg::ST_RECOVER;
            end
            else
            begin
               next_s.cnt = s.cnt - 1'b1;
            end
         end
         fifo_host_pkg::ST_WRITE:
         begin
            if (s.cnt == fifo_host_pkg::CNT_ZERO)
            begin
               next_s.ctl.write_n = 1'b1;
               next_s.wr_count = s.wr_count + 1'b1;
               // Leave time for the flags to settle before the next strobe.
               next_s.cnt = cyc(fifo_host_pkg::FLAG_CYC);
               next_s.st = fifo_host_pkg::ST_RECOVER;
            end
            else
            begin
               next_s.cnt = s.cnt - 1'b1;
            end
         end
         fifo_host_pkg::ST_READ:
         begin
            if (s.cnt == fifo_host_pkg::CNT_ZERO)
            begin
               next_s.ctl.read_n = 1'b1;
               next_s.read_data = fifo_stat_i.rdata;
               next_s.read_valid = 1'b1;
               next_s.check_pending = 1'b1;
               next_s.cnt = cyc(fifo_host_pkg::FLAG_CYC);
               next_s.st = fifo_host_pkg::ST_RECOVER;
            end
            else
            begin
               next_s.cnt = s.cnt - 1'b1;
            end
         end
         fifo_host_pkg::ST_REWIND:
         begin
            // Read strobe is held high from well before the rise.
            if (s.cnt == fifo_host_pkg::CNT_ZERO)
            begin
               next_s.ctl.head_select_or_rewind_n = 1'b1;
               next_s.cnt = cyc(fifo_host_pkg::FLAG_CYC);
               next_s.st = fifo_host_pkg::ST_RECOVER;
            end
            else
            begin
               next_s.cnt = s.cnt - 1'b1;
            end
         end
         fifo_host_pkg::ST_RECOVER:
         begin
            if (s.cnt == fifo_host_pkg::CNT_ZERO)
            begin
               next_s.st = fifo_host_pkg::ST_IDLE;
               next_s.busy = 1'b0;
            end
            else
            begin
               next_s.cnt = s.cnt - 1'b1;
            end
         end
         default:
         begin
            next_s.st = fifo_host_pkg::ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s <= RESET_STATE;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign busy_o = s.busy;
   assign read_valid_o = s.read_valid;
   assign read_data_o = s.read_data;
   assign rewind_refused_o = s.rewind_refused;
   assign mismatch_o = s.mismatch;
   assign fifo_ctl_o = s.ctl;

endmodule

/* verif/fifo_host_ctrl_asserts.sv */
// Checker of pin timing and ordering for the FIFO host controller.
`timescale 1ns/1ns
module fifo_host_ctrl_asserts
(
   // Watched ports
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic busy_o,
   input wire logic read_valid_o,
   input wire fifo_host_pkg::fifo_ctl_t fifo_ctl_o,
   input wire fifo_host_pkg::fifo_stat_t fifo_stat_i
);
   logic cl, wr, rd, rw, xi, full, empty;
   assign cl = fifo_ctl_o.pointer_clear_n;
   assign wr = fifo_ctl_o.write_n;
   assign rd = fifo_ctl_o.read_n;
   assign rw = fifo_ctl_o.head_select_or_rewind_n;
   assign xi = fifo_ctl_o.chain_in_n;
   assign full = fifo_stat_i.full_flag_n[0];
   assign empty = fifo_stat_i.empty_flag_n[0];
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////////////
   a_write_pulse_width: assert property ($fell(wr) |-> ##1 !wr [*8] ##1 wr)
      else $error("write strobe width wrong");
   a_read_pulse_width: assert property ($fell(rd) |-> ##1 !rd [*8] ##1 rd)
      else $error("read strobe width wrong");
   a_rewind_pulse_shape: assert property ($fell(rw) |-> ##1 !rw [*8] ##1 rw)
      else $error("rewind pulse shape wrong");
   a_clear_pulse_width: assert property ($fell(cl) |-> ##1 !cl [*8] ##1 cl)
      else $error("clear pulse width wrong");
   a_rewind_read_idle: assert property (!rw |-> rd)
      else $error("read strobe active during rewind");
   a_rewind_read_recovery: assert property ($rose(rw) |-> rd [*2])
      else $error("read strobe too soon after rewind");
   a_clear_strobes_idle: assert property (!cl |-> wr && rd)
      else $error("strobe active during clear");
   a_clear_single_mode: assert property (!cl |-> !xi)
      else $error("chain input high during clear");
   a_write_not_full: assert property ($fell(wr) |-> busy_o && $past(full))
      else $error("write started while full");
   a_read_not_empty: assert property ($fell(rd) |-> $past(empty))
      else $error("read started while empty");
   a_read_result_pulse: assert property ($rose(rd) |-> read_valid_o ##1 !read_valid_o)
      else $error("read result pulse wrong");
   c_write: cover property ($fell(wr));
   c_read: cover property ($fell(rd) ##9 $rose(rd));
   c_rewind: cover property ($rose(rw));
endmodule
bind fifo_host_ctrl fifo_host_ctrl_asserts u_chk
(
   .clk_i(clk_i), .rst_i(rst_i), .busy_o(busy_o), .read_valid_o(read_valid_o),
   .fifo_ctl_o(fifo_ctl_o), .fifo_stat_i(fifo_stat_i)
);

/* verif/fifo_pair_model.sv */
// Behavioural model of a width-expanded pair of FIFO devices.
`timescale 1ns/1ns
module fifo_pair_model
(
   // Pins from the controller
   input wire fifo_host_pkg::fifo_ctl_t ctl_i,
   input wire logic flip_i,
   // Pins toward the controller
   output fifo_host_pkg::fifo_stat_t stat_o
);
   logic [8:0] mem [512];
   logic [8:0] q = 9'h000;
   int wp = 0, rp = 0, cnt = 0;
   bit wok, rok;
   bit armed = 1'b0;
   always @(negedge ctl_i.pointer_clear_n)
   begin
      wp = 0;
      rp = 0;
      cnt = 0;
   end
   // A low chain input or a low head select at the end of clear lets writes start at once.
   always @(posedge ctl_i.pointer_clear_n)
      armed = !ctl_i.chain_in_n || !ctl_i.head_select_or_rewind_n;
   // A later device waits for a chain pulse; chain outputs and gated reads are left out
   // because the pair is never chained.
   always @(negedge ctl_i.chain_in_n)
      armed = 1'b1;
   always @(negedge ctl_i.head_select_or_rewind_n)
   begin
      rp = 0;
      cnt = wp;
   end
   always @(negedge ctl_i.write_n)
      wok = cnt < 512 && armed;
   always @(posedge ctl_i.write_n)
      if (wok)
      begin
         mem[wp] = ctl_i.wdata;
         wp = (wp + 1) % 512;
         cnt++;
         wok = 0;
      end
   always @(negedge ctl_i.read_n)
   begin
      rok = cnt > 0;
      if (rok)
      begin
         q = mem[rp];
         rp = (rp + 1) % 512;
         cnt--;
      end
   end
   // Released outputs show the inverse so a late sample cannot pass by luck.
   always @(posedge ctl_i.read_n)
      #5 rok = 0;
   assign stat_o = {{2{cnt < 512}}, {2{cnt > 0}},
                    rok ? {q, q ^ {8'h00, flip_i}} : ~{q, q}};
endmodule

/* verif/tb_fifo_host_ctrl.sv */
// Self-checking testbench for the FIFO host controller with a device pair model.
`timescale 1ns/1ns
module tb_fifo_host_ctrl;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic clear_req_i = 1'b0, write_req_i = 1'b0, read_req_i = 1'b0, rewind_req_i = 1'b0;
   logic flip = 1'b0;
   logic [8:0] write_data_i = 9'h000;
   logic busy_o, read_valid_o, rewind_refused_o, mismatch_o;
   logic [17:0] read_data_o;
   fifo_host_pkg::fifo_ctl_t fifo_ctl_o;
   fifo_host_pkg::fifo_stat_t fifo_stat_i;
   int errors = 0, num_checks = 0, cycles = 0, refusals = 0, exp_ref = 0;
   integer seed = 32'h8708_428b;
   logic [8:0] ref_q[$], hist[$];
   logic [17:0] got[$];
   initial forever #4 clk_i = ~clk_i;
   fifo_host_ctrl DUT
   (
      .clk_i(clk_i), .rst_i(rst_i), .clear_req_i(clear_req_i), .write_req_i(write_req_i),
      .write_data_i(write_data_i), .read_req_i(read_req_i), .rewind_req_i(rewind_req_i),
      .busy_o(busy_o), .read_valid_o(read_valid_o), .read_data_o(read_data_o),
      .rewind_refused_o(rewind_refused_o), .mismatch_o(mismatch_o),
      .fifo_ctl_o(fifo_ctl_o), .fifo_stat_i(fifo_stat_i)
   );
   fifo_pair_model u_dev (.ctl_i(fifo_ctl_o), .flip_i(flip), .stat_o(fifo_stat_i));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Kinds: 0 clear, 1 write, 2 read, 3 rewind; the reference queue follows each one.
   task automatic op(input int kind, input logic [8:0] d = 9'h000);
      int n = 0;
      logic [8:0] w;
      @(posedge clk_i);
      write_data_i <= d;
      {clear_req_i, write_req_i, read_req_i, rewind_req_i} <= 4'h8 >> kind;
      @(posedge clk_i);
      {clear_req_i, write_req_i, read_req_i, rewind_req_i} <= 4'h0;
      #1;
      while (busy_o !== 1'b0 && n < 40)
      begin
         @(posedge clk_i);
         #1;
         n++;
      end
      repeat (2) @(posedge clk_i);
      if (n == 40)
         errors++;
      case (kind)
         0:
         begin
            ref_q.delete();
            hist.delete();
         end
         1:
            if (ref_q.size() < 512)
            begin
               ref_q.push_back(d);
               hist.push_back(d);
            end
         2:
         begin
            check("read count", 18'(got.size()), 18'(ref_q.size() > 0));
            if (got.size() > 0 && ref_q.size() > 0)
            begin
               w = ref_q.pop_front();
               check("read data", got.pop_front(), {w, w ^ {8'h00, flip}});
            end
         end
         default:
            if (hist.size() < 512)
               ref_q = hist;
            else
               exp_ref++;
      endcase
   endtask
   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      if (read_valid_o === 1'b1)
         got.push_back(read_data_o);
      if (rewind_refused_o === 1'b1)
         refusals <= refusals + 1;
      if (cycles == 40000)
      begin
         errors++;
         complete_run();
      end
   end
   initial
   begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      check("idle pins", 18'(fifo_ctl_o[13:9]), 18'h0_001e);
      op(2);
      op(0);
      check("mismatch after clear", 18'(mismatch_o), 18'h0_0000);
      for (int i = 0; i < 6; i++)
         op(1, 9'($random(seed)));
      for (int i = 0; i < 3; i++)
         op(2);
      op(3);
      for (int i = 0; i < 7; i++)
         op(2);
      check("mismatch after rewind", 18'(mismatch_o), 18'h0_0000);
      op(0);
      op(1, 9'($random(seed)));
      flip = 1'b1;
      op(2);
      flip = 1'b0;
      check("mismatch raised", 18'(mismatch_o), 18'h0_0001);
      op(0);
      for (int i = 0; i < 513; i++)
         op(1, 9'($random(seed)));
      op(3);
      check("rewind refusals", 18'(refusals), 18'(exp_ref));
      for (int i = 0; i < 513; i++)
         op(2);
      op(1, 9'($random(seed)));
      op(2);
      complete_run();
   end
endmodule
